// *** rtl/imsq_brg.sv ***
// Reloadable bit-rate down counter giving one tick per rollover
`timescale 1ns/1ps
module imsq_brg (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      load_i,
  input  wire logic                      run_i,
  input  wire logic [imsq_pkg::BRG_W-1:0] reload_i,
  output logic                           tick_o,
  output logic [imsq_pkg::BRG_W-1:0]     cnt_o
);

  logic [imsq_pkg::BRG_W-1:0] cnt_d;

  // Tick on zero while running, then roll over to the reload value
  always_comb begin
    tick_o = run_i && !load_i && (cnt_o == '0);
    cnt_d  = cnt_o;
    if (load_i || tick_o) begin
      cnt_d = reload_i;
    end else if (run_i) begin
      cnt_d = cnt_o - 1'b1;
    end
  end

  // Count register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_o <= '0;
    end else begin
      cnt_o <= cnt_d;
    end
  end

endmodule

// *** rtl/imsq_sync.sv ***
// Two-flop synchroniser for one bus line sampled from outside
`timescale 1ns/1ps
module imsq_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;
  logic meta_d;
  logic sync_d;

  // Next values: first flop feeds only the second
  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  // Lines idle high, so reset to one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_q <= meta_d;
      q_o    <= sync_d;
    end
  end

endmodule

// *** rtl/imsq_top.sv ***
// Acknowledge and Stop sequencer of the two-wire master with AXI4-Lite slave
`timescale 1ns/1ps

// Operation
// - Setting the ack enable pulls SCL low and puts the ack data value on SDA.
// - The counter runs one full period with SCL low, then SCL is released.
// - Once SCL reads high the counter runs one more period, then SCL goes low.
// - At the end the ack enable clears, the counter stops and the port idles.
// - A buffer write during an ack sequence sets collision and is dropped.
// - After a finished byte SCL is held low past the ninth clock.
// - Setting the stop enable first pulls SDA low.
// - When SDA reads low the counter reloads and counts down to zero.
// - On timeout SCL is released, and a period later SDA is released.
// - Stop detected is set when SDA reads high while SCL is high.
// - A period after stop detect the stop enable clears and the irq is set.
// - A buffer write during a stop sequence sets collision and is dropped.
module imsq_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  output logic [1:0]       S_AXI_BRESP_O,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  input  wire logic        BYTE_DONE_I,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  output logic             IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  imsq_pkg::imsq_state_t       st_q, st_d;
  imsq_pkg::imsq_drive_t       drv_q, drv_d;
  imsq_pkg::imsq_stat_t        stat_q, stat_d, stat_set;
  imsq_pkg::imsq_ctrl_t        wctl;
  logic                        ack_en_q, ack_en_d;
  logic                        pen_q, pen_d;
  logic                        hold_q, hold_d;
  logic                        ack_dt_q, ack_dt_d;
  logic [2:0]                  mask_q, mask_d;
  logic [7:0]                  reload_q, reload_d;
  logic [7:0]                  buf_q, buf_d;
  logic                        aw_have_q, aw_have_d;
  logic                        w_have_q, w_have_d;
  logic [7:0]                  wa_q, wa_d;
  logic [31:0]                 wd_q, wd_d;
  logic                        ws_q, ws_d;
  logic                        bvalid_q, bvalid_d;
  logic [1:0]                  bresp_q, bresp_d;
  logic                        rvalid_q, rvalid_d;
  logic [31:0]                 rdata_q, rdata_d;
  logic [1:0]                  rresp_q, rresp_d;
  logic                        wr_go, rd_go, stat_clr;
  logic                        wr_ctrl, wr_buf;
  logic                        busy, start_ack, start_stop;
  logic                        brg_load, brg_run, brg_tick;
  logic [imsq_pkg::BRG_W-1:0]  brg_cnt;
  logic                        scl_s, sda_s;

  // Address match shared by the write and read decoders
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a[7:2] == r[7:2]);
  endfunction

  // Mapped register test for the response code
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, imsq_pkg::ADDR_CTRL)   || hit(a, imsq_pkg::ADDR_STATUS) ||
             hit(a, imsq_pkg::ADDR_MASK)   || hit(a, imsq_pkg::ADDR_RELOAD) ||
             hit(a, imsq_pkg::ADDR_BUFFER) || hit(a, imsq_pkg::ADDR_STATE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus line synchronisers and bit-rate counter
  imsq_sync u_scl_sync (
    .clk_i (CLOCK_I),
    .rst_i (RESET_I),
    .d_i   (SCL_I),
    .q_o   (scl_s)
  );

  imsq_sync u_sda_sync (
    .clk_i (CLOCK_I),
    .rst_i (RESET_I),
    .d_i   (SDA_I),
    .q_o   (sda_s)
  );

  imsq_brg u_brg (
    .clk_i    (CLOCK_I),
    .rst_i    (RESET_I),
    .load_i   (brg_load),
    .run_i    (brg_run),
    .reload_i (reload_q),
    .tick_o   (brg_tick),
    .cnt_o    (brg_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken in either order
  assign S_AXI_AWREADY_O = !aw_have_q;
  assign S_AXI_WREADY_O  = !w_have_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ctrl = wr_go && ws_q && hit(wa_q, imsq_pkg::ADDR_CTRL);
  assign wr_buf  = wr_go && ws_q && hit(wa_q, imsq_pkg::ADDR_BUFFER);
  assign wctl    = imsq_pkg::imsq_ctrl_t'(wd_q[2:0]);

  // Next values of the write channel
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    wa_d      = wa_q;
    wd_d      = wd_q;
    ws_d      = ws_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (S_AXI_AWVALID_I && !aw_have_q) begin
      aw_have_d = 1'b1;
      wa_d      = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !w_have_q) begin
      w_have_d = 1'b1;
      wd_d     = S_AXI_WDATA_I;
      ws_d     = S_AXI_WSTRB_I[0];
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(wa_q) ? imsq_pkg::RESP_OKAY : imsq_pkg::RESP_SLVERR;
    end else if (bvalid_q && S_AXI_BREADY_I) begin
      bvalid_d = 1'b0;
    end
  end

  // Write channel registers
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      wa_q      <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= imsq_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      wa_q      <= wa_d;
      wd_q      <= wd_d;
      ws_q      <= ws_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel; a status read clears the sticky bits
  assign S_AXI_ARREADY_O = !rvalid_q;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = rresp_q;
  assign rd_go    = S_AXI_ARVALID_I && !rvalid_q;
  assign stat_clr = rd_go && hit(S_AXI_ARADDR_I, imsq_pkg::ADDR_STATUS);

  // Read data multiplexer and valid
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(S_AXI_ARADDR_I) ? imsq_pkg::RESP_OKAY
                                         : imsq_pkg::RESP_SLVERR;
      rdata_d  = 32'h0000_0000;
      if (hit(S_AXI_ARADDR_I, imsq_pkg::ADDR_CTRL)) begin
        rdata_d[2:0] = {ack_dt_q, pen_q, ack_en_q};
      end else if (hit(S_AXI_ARADDR_I, imsq_pkg::ADDR_STATUS)) begin
        rdata_d[2:0] = stat_q;
      end else if (hit(S_AXI_ARADDR_I, imsq_pkg::ADDR_MASK)) begin
        rdata_d[2:0] = mask_q;
      end else if (hit(S_AXI_ARADDR_I, imsq_pkg::ADDR_RELOAD)) begin
        rdata_d[7:0] = reload_q;
      end else if (hit(S_AXI_ARADDR_I, imsq_pkg::ADDR_BUFFER)) begin
        rdata_d[7:0] = buf_q;
      end else if (hit(S_AXI_ARADDR_I, imsq_pkg::ADDR_STATE)) begin
        rdata_d[11:0] = {hold_q, sda_s, scl_s, st_q};
      end
    end else if (rvalid_q && S_AXI_RREADY_I) begin
      rvalid_d = 1'b0;
    end
  end

  // Read channel registers
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= imsq_pkg::RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: ack and stop phases on the bit-rate counter
  assign busy       = ack_en_q || pen_q;
  assign start_ack  = wr_ctrl && wctl.ack_en && (st_q == imsq_pkg::ST_IDLE);
  assign start_stop = wr_ctrl && wctl.stop_en && !wctl.ack_en &&
                      (st_q == imsq_pkg::ST_IDLE);
  assign brg_run    = (st_q == imsq_pkg::ST_ACK_LOW)  ||
                      (st_q == imsq_pkg::ST_ACK_HIGH) ||
                      (st_q == imsq_pkg::ST_STP_LOW)  ||
                      (st_q == imsq_pkg::ST_STP_SCLH) ||
                      (st_q == imsq_pkg::ST_STP_DONE);

  // Next state, enables, events and pin drive
  always_comb begin
    st_d     = st_q;
    ack_en_d = ack_en_q;
    pen_d    = pen_q;
    hold_d   = hold_q || BYTE_DONE_I;
    brg_load = 1'b0;
    stat_set = '0;
    case (st_q)
      imsq_pkg::ST_IDLE: begin
        if (start_ack) begin
          st_d     = imsq_pkg::ST_ACK_LOW;
          ack_en_d = 1'b1;
          brg_load = 1'b1;
        end else if (start_stop) begin
          st_d  = imsq_pkg::ST_STP_SDA;
          pen_d = 1'b1;
        end
      end
      imsq_pkg::ST_ACK_LOW: begin
        if (brg_tick) st_d = imsq_pkg::ST_ACK_REL;
      end
      imsq_pkg::ST_ACK_REL: begin
        if (scl_s) begin
          st_d     = imsq_pkg::ST_ACK_HIGH;
          brg_load = 1'b1;
        end
      end
      imsq_pkg::ST_ACK_HIGH: begin
        if (brg_tick) begin
          st_d     = imsq_pkg::ST_IDLE;
          ack_en_d = 1'b0;
          hold_d   = 1'b1;
        end
      end
      imsq_pkg::ST_STP_SDA: begin
        if (!sda_s) begin
          st_d     = imsq_pkg::ST_STP_LOW;
          brg_load = 1'b1;
        end
      end
      imsq_pkg::ST_STP_LOW: begin
        if (brg_tick) begin
          st_d   = imsq_pkg::ST_STP_SCLH;
          hold_d = 1'b0;
        end
      end
      imsq_pkg::ST_STP_SCLH: begin
        if (brg_tick) st_d = imsq_pkg::ST_STP_SDAH;
      end
      imsq_pkg::ST_STP_SDAH: begin
        if (sda_s && scl_s) begin
          st_d          = imsq_pkg::ST_STP_DONE;
          stat_set.stop = 1'b1;
          brg_load      = 1'b1;
        end
      end
      imsq_pkg::ST_STP_DONE: begin
        if (brg_tick) begin
          st_d         = imsq_pkg::ST_IDLE;
          pen_d        = 1'b0;
          stat_set.irq = 1'b1;
        end
      end
      default: st_d = imsq_pkg::ST_IDLE;
    endcase
    stat_set.write_collision_flag = wr_buf && busy;
    // Open-drain drive for the state being entered
    drv_d = '0;
    case (st_d)
      imsq_pkg::ST_IDLE:     drv_d.scl_oe = hold_d;
      imsq_pkg::ST_ACK_LOW:  drv_d = '{scl_oe: 1'b1, sda_oe: !ack_dt_d};
      imsq_pkg::ST_ACK_REL,
      imsq_pkg::ST_ACK_HIGH: drv_d.sda_oe = !ack_dt_d;
      imsq_pkg::ST_STP_SDA,
      imsq_pkg::ST_STP_LOW:  drv_d = '{scl_oe: 1'b1, sda_oe: 1'b1};
      imsq_pkg::ST_STP_SCLH: drv_d.sda_oe = 1'b1;
      default:               drv_d = '0;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_q     <= imsq_pkg::ST_IDLE;
      ack_en_q <= 1'b0;
      pen_q    <= 1'b0;
      hold_q   <= 1'b0;
      drv_q    <= '0;
    end else begin
      st_q     <= st_d;
      ack_en_q <= ack_en_d;
      pen_q    <= pen_d;
      hold_q   <= hold_d;
      drv_q    <= drv_d;
    end
  end

  // Lines are only ever pulled low
  assign SCL_O    = 1'b0;
  assign SDA_O    = 1'b0;
  assign SCL_OE_O = drv_q.scl_oe;
  assign SDA_OE_O = drv_q.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers, sticky status with set winning over read-clear
  always_comb begin
    ack_dt_d = ack_dt_q;
    mask_d   = mask_q;
    reload_d = reload_q;
    buf_d    = buf_q;
    stat_d   = (stat_clr ? imsq_pkg::STAT_RST : stat_q) | stat_set;
    if (wr_ctrl && !busy) ack_dt_d = wctl.ack_data;
    if (wr_go && ws_q && hit(wa_q, imsq_pkg::ADDR_MASK)) begin
      mask_d = wd_q[2:0];
    end
    if (wr_go && ws_q && hit(wa_q, imsq_pkg::ADDR_RELOAD)) begin
      reload_d = wd_q[7:0];
    end
    if (wr_buf && !busy) buf_d = wd_q[7:0];
  end

  // Register file flops
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_dt_q <= 1'b0;
      mask_q   <= imsq_pkg::MASK_RST;
      reload_q <= imsq_pkg::RELOAD_RST;
      buf_q    <= imsq_pkg::BUFFER_RST;
      stat_q   <= imsq_pkg::STAT_RST;
    end else begin
      ack_dt_q <= ack_dt_d;
      mask_q   <= mask_d;
      reload_q <= reload_d;
      buf_q    <= buf_d;
      stat_q   <= stat_d;
    end
  end

  // Level interrupt from unmasked sticky bits
  assign IRQ_O = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  chk_ack_drive: assert property (
    st_q == imsq_pkg::ST_ACK_LOW |-> SCL_OE_O && (SDA_OE_O == !ack_dt_q))
    else $error("ack phase drive wrong");
  chk_ack_release: assert property (
    st_q == imsq_pkg::ST_ACK_LOW && brg_tick |=> !SCL_OE_O [*2])
    else $error("SCL not released after low period");
  chk_ack_stretch: assert property (
    st_q == imsq_pkg::ST_ACK_REL && !scl_s |=> st_q == imsq_pkg::ST_ACK_REL)
    else $error("ack left wait while SCL low");
  chk_ack_finish: assert property (
    st_q == imsq_pkg::ST_ACK_HIGH && brg_tick |=>
      !ack_en_q && SCL_OE_O && !brg_run)
    else $error("ack end wrong");
  chk_write_collision_flag_ack: assert property (
    wr_buf && ack_en_q |=> stat_q.write_collision_flag && $stable(buf_q))
    else $error("collision during ack missed");
  chk_hold_low: assert property (
    st_q == imsq_pkg::ST_IDLE && hold_q |-> SCL_OE_O)
    else $error("SCL not held low");
  chk_stop_sda: assert property (
    start_stop |=> SDA_OE_O && SCL_OE_O)
    else $error("stop did not pull SDA low");
  chk_stop_reload: assert property (
    st_q == imsq_pkg::ST_STP_SDA && !sda_s |=> brg_cnt == reload_q)
    else $error("counter not reloaded");
  chk_stop_sda_rel: assert property (
    st_q == imsq_pkg::ST_STP_SCLH && brg_tick |=> !SDA_OE_O && !SCL_OE_O)
    else $error("SDA not released");
  chk_stop_detect: assert property (
    st_q == imsq_pkg::ST_STP_SDAH && sda_s && scl_s |=> stat_q.stop)
    else $error("stop detect not flagged");
  chk_stop_finish: assert property (
    st_q == imsq_pkg::ST_STP_DONE && brg_tick |=> !pen_q && stat_q.irq)
    else $error("stop end wrong");
  chk_write_collision_flag_stop: assert property (
    wr_buf && pen_q |=> stat_q.write_collision_flag && $stable(buf_q))
    else $error("collision during stop missed");
  chk_brg_period: assert property (
    brg_run && !brg_load && !brg_tick |=>
      brg_cnt == $past(brg_cnt) - 8'h01)
    else $error("bit period length wrong");

  cov_ack_done: cover property (
    st_q == imsq_pkg::ST_ACK_HIGH && brg_tick);
  cov_stop_done: cover property (
    st_q == imsq_pkg::ST_STP_DONE && brg_tick);
  cov_write_collision_flag: cover property (wr_buf && busy);

endmodule

// *** shared/imsq_pkg.sv ***
// Constants, state codes and carrier types of the acknowledge/stop sequencer
package imsq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0C;
  localparam logic [7:0] ADDR_BUFFER = 8'h10;
  localparam logic [7:0] ADDR_STATE  = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int         BRG_W      = 8;
  localparam int         STAT_W     = 3;
  localparam logic [7:0] RELOAD_RST = 8'h09;
  localparam logic [7:0] BUFFER_RST = 8'h00;
  localparam logic [2:0] MASK_RST   = 3'h0;
  localparam logic [2:0] STAT_RST   = 3'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ACK_LOW  = 9'h002,
    ST_ACK_REL  = 9'h004,
    ST_ACK_HIGH = 9'h008,
    ST_STP_SDA  = 9'h010,
    ST_STP_LOW  = 9'h020,
    ST_STP_SCLH = 9'h040,
    ST_STP_SDAH = 9'h080,
    ST_STP_DONE = 9'h100
  } imsq_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers: control word, sticky status, pin drive, state view
  typedef struct packed {
    logic ack_data;
    logic stop_en;
    logic ack_en;
  } imsq_ctrl_t;

  typedef struct packed {
    logic irq;
    logic write_collision_flag;
    logic stop;
  } imsq_stat_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } imsq_drive_t;

  typedef struct packed {
    logic        hold;
    logic        sda;
    logic        scl;
    imsq_state_t st;
  } imsq_view_t;

endpackage

// *** verif/i2c_master_ack_stop_sequencer_tb_top.sv ***
// Bench top: drives the sequencer over AXI4-Lite and checks its pins
`timescale 1ns/1ps
module i2c_master_ack_stop_sequencer_tb_top;
  logic        clk, rst, awv, wv, brdy, arv, rrdy, bdone, ad;
  logic [7:0]  awa, ara, bufv;
  logic [31:0] wd, rd, rdata;
  logic [1:0]  rsp, bresp, rresp;
  logic        scl_oe, sda_oe, scl_w, sda_w, scl_o, sda_o, irq;
  logic        awrdy, wrdy, bv, arrdy, rv, p_so, p_do, p_sw, p_dw;
  int          error_cnt, check_count, cyc, stretch, r, n;
  int          t_sr, t_sf, t_df, t_sw, t_dw;

  imsq_top imsq_top_i (
    .CLOCK_I(clk), .RESET_I(rst),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_AWADDR_I(awa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .BYTE_DONE_I(bdone),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .IRQ_O(irq));

  imsq_slave_model imsq_slave_model_i (
    .clk_i(clk), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .stretch_i(stretch), .scl_o(scl_w), .sda_o(sda_w));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Edge times of drives and wires, plus the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    {p_so, p_do, p_sw, p_dw} <= {scl_oe, sda_oe, scl_w, sda_w};
    if (!p_so && scl_oe) t_sr <= cyc;
    if (p_so && !scl_oe) t_sf <= cyc;
    if (p_do && !sda_oe) t_df <= cyc;
    if (!p_sw && scl_w) t_sw <= cyc;
    if (p_dw && !sda_w) t_dw <= cyc;
    if (cyc > 20000) begin
      error_cnt++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Duration in cycles must fall inside a window
  task automatic chk_span(input int d, input int lo, input int hi);
    check_count++;
    if (d < lo || d > hi) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, d, lo);
    end
  endtask

  // Each channel drops valid only at the edge that takes it; ready stays up
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; brdy <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    rsp = bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    arv <= 1'b1; ara <= a; rrdy <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
    end while (!rv);
    rd = rdata;
    rsp = rresp;
  endtask

  // Wait for a drive level, then one edge so the edge times land
  task automatic wait_pin(ref logic s, input logic v);
    for (n = 0; n < 400 && s !== v; n++) @(posedge clk);
    @(posedge clk);
  endtask

  task automatic wait_idle(input int b);
    for (int k = 0; k < 100; k++) begin
      axi_rd(imsq_pkg::ADDR_CTRL);
      if (rd[b] === 1'b0) break;
    end
  endtask

  task automatic summarize();
    $display("Errors %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; awv = 1'b0; wv = 1'b0; brdy = 1'b0; arv = 1'b0;
    rrdy = 1'b0; bdone = 1'b0; awa = 8'h00; ara = 8'h00; wd = 32'h0;
    {p_so, p_do, p_sw, p_dw} = 4'h3;
    error_cnt = 0; check_count = 0; cyc = 0; stretch = 0;
    void'($urandom(95));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    r = 2 + $urandom % 4;
    stretch = $urandom % 6;
    ad = $urandom % 2;
    bufv = $urandom % 256;
    // Reset values, unmapped access and the open-drain data levels
    axi_rd(imsq_pkg::ADDR_RELOAD);
    chk(rd, {24'h0, imsq_pkg::RELOAD_RST});
    axi_rd(8'h1C);
    chk({30'h0, rsp}, {30'h0, imsq_pkg::RESP_SLVERR});
    axi_wr(8'h1C, 32'h0);
    chk({30'h0, rsp}, {30'h0, imsq_pkg::RESP_SLVERR});
    chk({30'h0, scl_o, sda_o}, 32'h0);
    // Acknowledge with random data, period and slave stretch
    axi_wr(imsq_pkg::ADDR_RELOAD, r);
    axi_wr(imsq_pkg::ADDR_MASK, 32'h2);
    axi_wr(imsq_pkg::ADDR_BUFFER, {24'h0, bufv});
    axi_wr(imsq_pkg::ADDR_CTRL, {29'h0, ad, 2'h0});
    axi_wr(imsq_pkg::ADDR_CTRL, {29'h0, ad, 2'h1});
    repeat (2) @(posedge clk);
    chk({scl_oe, sda_oe}, {30'h0, 1'b1, !ad});
    wait_pin(scl_oe, 1'b0);
    chk_span(t_sf - t_sr, r + 1, r + 2);
    axi_wr(imsq_pkg::ADDR_BUFFER, {24'h0, ~bufv});
    wait_pin(scl_oe, 1'b1);
    chk_span(t_sr - t_sw, r + 1, r + 5);
    wait_idle(0);
    chk(scl_oe, 32'h1);
    axi_rd(imsq_pkg::ADDR_STATE);
    chk({23'h0, rd[8:0]}, {23'h0, imsq_pkg::ST_IDLE});
    axi_rd(imsq_pkg::ADDR_BUFFER);
    chk(rd[7:0], bufv);
    chk(irq, 32'h1);
    axi_rd(imsq_pkg::ADDR_STATUS);
    chk(rd[1:0], 32'h2);
    chk(irq, 32'h0);
    // Finished byte keeps SCL held low
    bdone <= 1'b1;
    @(posedge clk);
    bdone <= 1'b0;
    repeat (2) @(posedge clk);
    axi_rd(imsq_pkg::ADDR_STATE);
    chk({rd[11], scl_oe}, 32'h3);
    // Stop sequence with a colliding buffer write
    axi_wr(imsq_pkg::ADDR_MASK, 32'h4);
    axi_wr(imsq_pkg::ADDR_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk({scl_oe, sda_oe}, 32'h3);
    wait_pin(scl_oe, 1'b0);
    chk_span(t_sf - t_dw, r + 1, r + 5);
    axi_wr(imsq_pkg::ADDR_BUFFER, {24'h0, ~bufv});
    chk(irq, 32'h0);
    wait_pin(sda_oe, 1'b0);
    chk_span(t_df - t_sf, r + 1, r + 2);
    wait_idle(1);
    chk({scl_w, sda_w, irq}, 32'h7);
    axi_rd(imsq_pkg::ADDR_BUFFER);
    chk(rd[7:0], bufv);
    axi_rd(imsq_pkg::ADDR_STATUS);
    chk(rd[2:0], 32'h7);
    axi_rd(imsq_pkg::ADDR_STATUS);
    chk({rd[2:0], irq}, 32'h0);
    // Finished byte after the stop, with SCL released, pulls SCL low again
    bdone <= 1'b1;
    @(posedge clk);
    bdone <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, scl_oe}, 32'h1);
    summarize();
  end
endmodule

// *** verif/imsq_slave_model.sv ***
// Behavioural two-wire slave: line pull-ups and clock stretching
`timescale 1ns/1ps
module imsq_slave_model (
  input  wire logic        clk_i,
  input  wire logic        scl_oe_i,
  input  wire logic        sda_oe_i,
  input  wire logic [31:0] stretch_i,
  output logic             scl_o,
  output logic             sda_o
);
  int cnt = 0;
  // Reload the stretch count while the master pulls SCL low
  always @(posedge clk_i) begin
    if (scl_oe_i) cnt <= stretch_i;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // Open-drain wires: low while any party pulls, pulled up otherwise
  assign scl_o = !(scl_oe_i || cnt > 0);
  assign sda_o = !sda_oe_i;
endmodule
